/* File: src/fmi2s_pkg.sv */
// constants shared by the fm serial audio port and its helpers.
// assumes a single 50 MHz core clock; no software-visible registers.
//
// Notes on behaviour
// R01: receive path master or slave; transmit slave only
// R02: master drives clock and select; sdo always driven
// R03: sdi feeds transmit path; sdo carries receive audio
// R04: sixteen-bit words, most significant bit first
// R05: msb one bit after select edge, falling launch
// R06: select low is left, high is right
// R07: far end samples our data on rising edge
// R08: master frame of 32 or 50 bit clocks
// R09: fractional divider from reference, one-cycle jitter
// R10: external slave clock at most 6 MHz; the bench codec model drives a 160 ns bit clock, 6.25 MHz
// R11: receive master uses 48 kHz, 1.536 MHz narrow or 2.4 MHz wide
// R12: pins routable to voice or control set
// R13: master or slave chosen by host configuration
// R14: unused wide-frame bit slots low, ignored in
// R15: voice pins carry left then right, msb first
package fmi2s_pkg;
	localparam int WORD_BITS = 16;
	localparam int FRAME_NARROW = 32;
	localparam int FRAME_WIDE = 50;
	localparam int FRAME_RATE_HZ = 48000;
	localparam int MCLK_HZ = 50000000;
	localparam int SLAVE_SCK_MAX_HZ = 6000000;
	localparam int FIFO_DEPTH = 8;
	// two half-periods per bit clock, so the divider ticks twice per bit
	localparam int DIV_MOD = MCLK_HZ;
	localparam int DIV_STEP_NARROW = 2 * FRAME_RATE_HZ * FRAME_NARROW;
	localparam int DIV_STEP_WIDE = 2 * FRAME_RATE_HZ * FRAME_WIDE;
	localparam int ACC_W = 27;
	localparam logic [5:0] HALF_NARROW = 6'(FRAME_NARROW / 2);
	localparam logic [5:0] HALF_WIDE = 6'(FRAME_WIDE / 2);
	localparam logic [5:0] LAST_NARROW = 6'(FRAME_NARROW - 1);
	localparam logic [5:0] LAST_WIDE = 6'(FRAME_WIDE - 1);
	localparam logic [4:0] WORD_BITS_C = 5'(WORD_BITS);
	localparam logic [4:0] WORD_LAST_C = 5'(WORD_BITS - 1);
	localparam logic [1:0] ROUTE_VOICE = 2'h1;
	localparam logic [1:0] ROUTE_CTL = 2'h2;
	typedef enum logic {CAP_IDLE, CAP_SHIFT} fmi2s_cap_t;
endpackage : fmi2s_pkg

/* File: src/fmi2s_stream_if.sv */
// valid/ready word channel between the port and its fifo.
// assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface fmi2s_stream_if #(parameter int W = 32);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : fmi2s_stream_if

/* File: src/fmi2s_fifo.sv */
// small word fifo with a registered output stage.
// assumes one clock; push and pop follow valid/ready.
`timescale 1ns/1ps
module fmi2s_fifo #(
	parameter int W = 32,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic en,
	fmi2s_stream_if.snk push,
	fmi2s_stream_if.src pop
);
	localparam int AW = $clog2(DEPTH);
	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
			$error("fmi2s_fifo depth must be a power of two, at least 2");
		end
	endgenerate

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
	logic [AW:0] count, next_count;
	logic spaceOk, next_spaceOk;
	logic outValid, next_outValid;
	logic [W-1:0] outData, next_outData;
	logic doWr, doRd;

	assign push.ready = spaceOk;
	assign pop.valid = outValid;
	assign pop.data = outData;

	////////////////////////////////////////////////////////////////////////
	// pointer and output stage; ready is itself a flop, low in reset, so
	// the push side sees no comb path
	always_comb begin
		doWr = push.valid & spaceOk;
		doRd = (count != '0) & (~outValid | pop.ready);
		next_wrPtr = doWr ? AW'(wrPtr + 1'b1) : wrPtr;
		next_rdPtr = doRd ? AW'(rdPtr + 1'b1) : rdPtr;
		next_count = count;
		if (doWr && !doRd) begin
			next_count = (AW + 1)'(count + 1'b1);
		end else if (doRd && !doWr) begin
			next_count = (AW + 1)'(count - 1'b1);
		end
		next_spaceOk = (next_count != (AW + 1)'(DEPTH));
		next_outValid = outValid & ~pop.ready;
		next_outData = outData;
		if (doRd) begin
			next_outValid = 1'b1;
			next_outData = mem[rdPtr];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
			spaceOk <= 1'b0;
			outValid <= 1'b0;
			outData <= '0;
		end else if (en) begin
			wrPtr <= next_wrPtr;
			rdPtr <= next_rdPtr;
			count <= next_count;
			spaceOk <= next_spaceOk;
			outValid <= next_outValid;
			outData <= next_outData;
		end
	end

	// storage has no reset; nothing reads an unwritten entry
	always_ff @(posedge clk) begin
		if (en && doWr) begin
			mem[wrPtr] <= push.data;
		end
	end
endmodule : fmi2s_fifo

/* File: src/fmi2s_clkdiv.sv */
// fractional step/modulus divider producing half-period ticks.
// assumes step below modulus; output edges jitter by one clock.
`timescale 1ns/1ps
module fmi2s_clkdiv #(
	parameter int ACC_W = fmi2s_pkg::ACC_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic en,
	input wire logic run,
	input wire logic [ACC_W-1:0] step,
	input wire logic [ACC_W-1:0] modulus,
	output logic tick
);
	logic [ACC_W-1:0] acc, next_acc;
	logic next_tick;
	logic [ACC_W:0] sum;

	// accumulate step, wrap at modulus: average rate step/modulus
	always_comb begin
		sum = {1'b0, acc} + {1'b0, step};
		next_acc = acc;
		next_tick = 1'b0;
		if (!run) begin
			next_acc = '0;
		end else if (sum >= {1'b0, modulus}) begin
			next_acc = ACC_W'(sum - {1'b0, modulus}); // see R09
			next_tick = 1'b1;
		end else begin
			next_acc = ACC_W'(sum);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc <= '0;
			tick <= 1'b0;
		end else if (en) begin
			acc <= next_acc;
			tick <= next_tick;
		end
	end
endmodule : fmi2s_clkdiv

/* File: src/fmi2s_port.sv */
// fm serial audio port: receive audio out on sdo, transmit audio in.
// assumes config inputs come from host logic on mclk; pins are async.
`timescale 1ns/1ps
module fmi2s_port #(
	parameter int DEPTH = fmi2s_pkg::FIFO_DEPTH
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic masterMode,
	input wire logic wideFrame,
	input wire logic routeCtl,
	input wire logic [31:0] rxData,
	input wire logic rxValid,
	output logic rxReady,
	output logic [15:0] txData,
	output logic txRight,
	output logic txValid,
	input wire logic voiceSckIn,
	output logic voiceSckOut,
	output logic voiceSckOe,
	input wire logic voiceWsIn,
	output logic voiceWsOut,
	output logic voiceWsOe,
	output logic voiceSdo,
	output logic voiceSdoOe,
	input wire logic voiceSdi,
	input wire logic ctlSckIn,
	output logic ctlSckOut,
	output logic ctlSckOe,
	input wire logic ctlWsIn,
	output logic ctlWsOut,
	output logic ctlWsOe,
	output logic ctlSdo,
	output logic ctlSdoOe,
	input wire logic ctlSdi
);
	localparam int W = fmi2s_pkg::WORD_BITS;
	generate
		if (DEPTH != fmi2s_pkg::FIFO_DEPTH && DEPTH < 2) begin : g_bad
			$error("fmi2s_port fifo depth too small");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// fifo for receive-path words {left, right}
	fmi2s_stream_if #(.W(2 * W)) pushIf ();
	fmi2s_stream_if #(.W(2 * W)) popIf ();
	logic popReady;

	assign pushIf.valid = rxValid;
	assign pushIf.data = rxData;
	assign rxReady = pushIf.ready;
	assign popIf.ready = popReady;

	fmi2s_fifo #(.W(2 * W), .DEPTH(DEPTH)) u_fifo (
		.clk(mclk),
		.rst_n(rst_n),
		.en(clkEn),
		.push(pushIf),
		.pop(popIf)
	);

	////////////////////////////////////////////////////////////////////////
	// master bit clock divider, idle while slave
	logic divTick;
	logic [fmi2s_pkg::ACC_W-1:0] divStep;

	assign divStep = wideFrame ?
		fmi2s_pkg::ACC_W'(fmi2s_pkg::DIV_STEP_WIDE) :
		fmi2s_pkg::ACC_W'(fmi2s_pkg::DIV_STEP_NARROW); // see R08

	fmi2s_clkdiv u_div (
		.clk(mclk),
		.rst_n(rst_n),
		.en(clkEn),
		.run(masterMode), // see R13
		.step(divStep),
		.modulus(fmi2s_pkg::ACC_W'(fmi2s_pkg::DIV_MOD)),
		.tick(divTick)
	);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers: {ctlSdi, ctlWs, ctlSck, voiceSdi, voiceWs, voiceSck}
	logic [5:0] syncA, syncB;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			syncA <= '0;
			syncB <= '0;
		end else if (clkEn) begin
			syncA <= {ctlSdi, ctlWsIn, ctlSckIn, voiceSdi, voiceWsIn,
				voiceSckIn};
			syncB <= syncA;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// core state
	logic selSck, selWs, selSdi;
	logic sckPrev, next_sckPrev;
	logic sckGen, next_sckGen;
	logic wsGen, next_wsGen;
	logic [5:0] bitCnt, next_bitCnt;
	logic wsLast, next_wsLast;
	logic [W-1:0] shReg, next_shReg;
	logic [W-1:0] rightHold, next_rightHold;
	logic [4:0] bitsLeft, next_bitsLeft;
	logic sdo, next_sdo;
	logic armPend, next_armPend;
	logic armCh, next_armCh;
	fmi2s_pkg::fmi2s_cap_t capState, next_capState;
	logic capCh, next_capCh;
	logic [4:0] capCnt, next_capCnt;
	logic [W-1:0] capSh, next_capSh;
	logic [15:0] next_txData;
	logic next_txRight, next_txValid;
	logic sRise, sFall, doFall, doRise, wsNew, wsChange;
	logic [5:0] cntNew;

	// pin set chosen after the second sync stage
	assign selSck = routeCtl ? syncB[3] : syncB[0]; // see R12
	assign selWs = routeCtl ? syncB[4] : syncB[1];
	assign selSdi = routeCtl ? syncB[5] : syncB[2];

	// slave falls act at once so data reaches the pin before the far end's
	// next rise; limitation: select must move together with that fall
	always_comb begin
		sRise = selSck & ~sckPrev;
		sFall = ~selSck & sckPrev;
		next_sckPrev = selSck;
		next_sckGen = masterMode ? (sckGen ^ divTick) : 1'b0; // see R09
		doFall = masterMode ? (divTick & sckGen) : sFall; // see R05
		doRise = ~masterMode & sRise; // see R01
		if (bitCnt == (wideFrame ? fmi2s_pkg::LAST_WIDE :
			fmi2s_pkg::LAST_NARROW)) begin
			cntNew = '0;
		end else begin
			cntNew = 6'(bitCnt + 1'b1);
		end
		wsNew = masterMode ?
			(cntNew >= (wideFrame ? fmi2s_pkg::HALF_WIDE :
			fmi2s_pkg::HALF_NARROW)) : selWs; // see R08
		wsChange = wsNew != wsLast;
	end

	// serializer and capture
	always_comb begin
		next_bitCnt = bitCnt;
		next_wsGen = masterMode ? wsGen : 1'b0;
		next_wsLast = wsLast;
		next_shReg = shReg;
		next_rightHold = rightHold;
		next_bitsLeft = bitsLeft;
		next_sdo = sdo;
		next_armPend = armPend;
		next_armCh = armCh;
		next_capState = capState;
		next_capCh = capCh;
		next_capCnt = capCnt;
		next_capSh = capSh;
		next_txData = txData;
		next_txRight = txRight;
		next_txValid = 1'b0;
		popReady = 1'b0;
		if (doFall) begin
			if (masterMode) begin
				next_bitCnt = cntNew;
				next_wsGen = wsNew; // see R02
			end
			next_wsLast = wsNew;
			// last bit of old word may share the select edge
			next_sdo = (bitsLeft != '0) & shReg[W-1]; // see R14
			if (wsChange) begin
				next_bitsLeft = fmi2s_pkg::WORD_BITS_C; // see R04
				next_armPend = 1'b1;
				next_armCh = wsNew;
				if (!wsNew) begin
					// left half: new frame word from the fifo, zeros on underrun
					popReady = 1'b1; // see R15
					next_shReg = popIf.valid ? popIf.data[2*W-1:W] : '0;
					next_rightHold = popIf.valid ? popIf.data[W-1:0] : '0;
				end else begin
					next_shReg = rightHold; // see R06
				end
			end else begin
				if (bitsLeft != '0) begin
					next_shReg = {shReg[W-2:0], 1'b0}; // see R05
					next_bitsLeft = 5'(bitsLeft - 1'b1);
				end
				if (armPend) begin
					next_armPend = 1'b0;
					next_capState = fmi2s_pkg::CAP_SHIFT;
					next_capCh = armCh;
					next_capCnt = '0;
				end
			end
		end
		// far end launches on falling, so sample on our rising edge
		if (doRise) begin
			case (capState)
				fmi2s_pkg::CAP_SHIFT: begin
					next_capSh = {capSh[W-2:0], selSdi}; // see R03
					next_capCnt = 5'(capCnt + 1'b1);
					if (capCnt == fmi2s_pkg::WORD_LAST_C) begin
						next_txData = {capSh[W-2:0], selSdi};
						next_txRight = capCh; // see R06
						next_txValid = 1'b1;
						next_capState = fmi2s_pkg::CAP_IDLE; // see R14
					end
				end
				fmi2s_pkg::CAP_IDLE: begin
					next_capState = fmi2s_pkg::CAP_IDLE;
				end
				default: begin
					next_capState = fmi2s_pkg::CAP_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sckPrev <= 1'b0;
			sckGen <= 1'b0;
			wsGen <= 1'b0;
			bitCnt <= '0;
			wsLast <= 1'b0;
			shReg <= '0;
			rightHold <= '0;
			bitsLeft <= '0;
			sdo <= 1'b0;
			armPend <= 1'b0;
			armCh <= 1'b0;
			capState <= fmi2s_pkg::CAP_IDLE;
			capCh <= 1'b0;
			capCnt <= '0;
			capSh <= '0;
			txData <= '0;
			txRight <= 1'b0;
			txValid <= 1'b0;
		end else if (clkEn) begin
			sckPrev <= next_sckPrev;
			sckGen <= next_sckGen;
			wsGen <= next_wsGen;
			bitCnt <= next_bitCnt;
			wsLast <= next_wsLast;
			shReg <= next_shReg;
			rightHold <= next_rightHold;
			bitsLeft <= next_bitsLeft;
			sdo <= next_sdo;
			armPend <= next_armPend;
			armCh <= next_armCh;
			capState <= next_capState;
			capCh <= next_capCh;
			capCnt <= next_capCnt;
			capSh <= next_capSh;
			txData <= next_txData;
			txRight <= next_txRight;
			txValid <= next_txValid;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin drivers, one registered set per pin group; unselected set floats
	logic [1:0] pSckO, pSckE, pWsO, pWsE, pSdoO, pSdoE;
	logic [1:0] routeSel;

	assign routeSel = routeCtl ? fmi2s_pkg::ROUTE_CTL :
		fmi2s_pkg::ROUTE_VOICE;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_pins
			logic nSckO, nSckE, nWsO, nWsE, nSdoO, nSdoE;
			always_comb begin
				nSckE = routeSel[g] & masterMode; // see R02
				nWsE = routeSel[g] & masterMode;
				nSdoE = routeSel[g]; // see R12
				nSckO = sckGen;
				nWsO = wsGen;
				nSdoO = sdo;
			end
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					pSckO[g] <= 1'b0;
					pSckE[g] <= 1'b0;
					pWsO[g] <= 1'b0;
					pWsE[g] <= 1'b0;
					pSdoO[g] <= 1'b0;
					pSdoE[g] <= 1'b0;
				end else if (clkEn) begin
					pSckO[g] <= nSckO;
					pSckE[g] <= nSckE;
					pWsO[g] <= nWsO;
					pWsE[g] <= nWsE;
					pSdoO[g] <= nSdoO;
					pSdoE[g] <= nSdoE;
				end
			end
		end
	endgenerate

	assign voiceSckOut = pSckO[0];
	assign voiceSckOe = pSckE[0];
	assign voiceWsOut = pWsO[0];
	assign voiceWsOe = pWsE[0];
	assign voiceSdo = pSdoO[0];
	assign voiceSdoOe = pSdoE[0];
	assign ctlSckOut = pSckO[1];
	assign ctlSckOe = pSckE[1];
	assign ctlWsOut = pWsO[1];
	assign ctlWsOe = pWsE[1];
	assign ctlSdo = pSdoO[1];
	assign ctlSdoOe = pSdoE[1];
endmodule : fmi2s_port

/* File: dv/fmi2s_port_properties.sv */
// assertions on the fm serial audio port pins and capture strobe.
// assumes config inputs only change while reset is held.
`timescale 1ns/1ps
module fmi2s_port_properties (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic masterMode,
	input wire logic wideFrame,
	input wire logic routeCtl,
	input wire logic txValid,
	input wire logic voiceSckOut,
	input wire logic voiceSckOe,
	input wire logic voiceWsOut,
	input wire logic voiceWsOe,
	input wire logic voiceSdo,
	input wire logic voiceSdoOe,
	input wire logic ctlSckOe,
	input wire logic ctlWsOe,
	input wire logic ctlSdoOe
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////
	// master bit clock high phase: 16..17 mclk narrow, 10..11 wide
	sequence s_hi8;
		voiceSckOut [*8];
	endsequence
	sequence s_start(logic w);
		masterMode && voiceSckOe && wideFrame == w && $rose(voiceSckOut);
	endsequence
	property p_sck_narrow;
		s_start(1'b0) |-> s_hi8 ##1 s_hi8 ##[1:2] $fell(voiceSckOut);
	endproperty
	a_sck_narrow: assert property (p_sck_narrow)
		else $error("narrow bit clock phase off");
	property p_sck_wide;
		s_start(1'b1) |-> s_hi8 ##1 voiceSckOut [*2] ##[1:2] $fell(voiceSckOut);
	endproperty
	a_sck_wide: assert property (p_sck_wide)
		else $error("wide bit clock phase off");
	////////////////////////////////////////////////////////////////////////
	// enables follow mode and pin set one cycle later
	property p_sdo_oe;
		$past(rst_n) |-> voiceSdoOe == !$past(routeCtl)
			&& ctlSdoOe == $past(routeCtl);
	endproperty
	a_sdo_oe: assert property (p_sdo_oe)
		else $error("data out enable wrong");
	property p_clk_oe;
		$past(rst_n) |-> voiceSckOe == ($past(masterMode) && !$past(routeCtl))
			&& voiceWsOe == voiceSckOe;
	endproperty
	a_clk_oe: assert property (p_clk_oe)
		else $error("clock enable wrong");
	property p_ws_oe;
		$past(rst_n) |-> ctlWsOe == ($past(masterMode) && $past(routeCtl))
			&& ctlSckOe == ctlWsOe;
	endproperty
	a_ws_oe: assert property (p_ws_oe)
		else $error("select enable wrong");
	////////////////////////////////////////////////////////////////////////
	// transmit capture: slave only, strobe one cycle wide
	property p_cap_off;
		masterMode [*8] |=> !txValid;
	endproperty
	a_cap_off: assert property (p_cap_off)
		else $error("capture seen in master");
	property p_tx_pulse;
		txValid |=> !txValid;
	endproperty
	a_tx_pulse: assert property (p_tx_pulse)
		else $error("capture strobe too long");
	// master outputs move only with a falling bit clock
	property p_ws_fall;
		$past(voiceSckOe) && voiceSckOe && $changed(voiceWsOut)
			|-> $fell(voiceSckOut);
	endproperty
	a_ws_fall: assert property (p_ws_fall)
		else $error("select moved off falling edge");
	property p_sdo_fall;
		$past(voiceSckOe) && voiceSckOe && $changed(voiceSdo)
			|-> $fell(voiceSckOut);
	endproperty
	a_sdo_fall: assert property (p_sdo_fall)
		else $error("data moved off falling edge");
endmodule : fmi2s_port_properties

bind fmi2s_port fmi2s_port_properties u_props (
	.mclk(mclk),
	.rst_n(rst_n),
	.masterMode(masterMode),
	.wideFrame(wideFrame),
	.routeCtl(routeCtl),
	.txValid(txValid),
	.voiceSckOut(voiceSckOut),
	.voiceSckOe(voiceSckOe),
	.voiceWsOut(voiceWsOut),
	.voiceWsOe(voiceWsOe),
	.voiceSdo(voiceSdo),
	.voiceSdoOe(voiceSdoOe),
	.ctlSckOe(ctlSckOe),
	.ctlWsOe(ctlWsOe),
	.ctlSdoOe(ctlSdoOe)
);

/* File: dv/fmi2s_codec_model.sv */
// codec model on the far side: bit clock master for the slave port.
// assumes one pin set routed to it; sck stands high between bursts.
`timescale 1ns/1ps
module fmi2s_codec_model (
	output logic sck,
	output logic ws,
	output logic sdi,
	input wire logic sdo
);
	logic [31:0] txw [16];
	logic [31:0] rxw [16];
	////////////////////////////////////////////////////////////////////////
	// idle levels before the first burst
	initial begin
		sck = 1'b1;
		ws = 1'b1;
		sdi = 1'b0;
	end
	// one bit slot: fall, then new select and data, rise, sample
	task automatic slot(input logic w, input logic d, output logic s);
		#80 sck = 1'b0;
		#1 ws = w;
		sdi = d;
		#79 sck = 1'b1;
		s = sdo;
	endtask : slot
	// lead-in slots raise then drop select, so the port sees a left start
	// whatever select it last saw; then n frames of 32 clocks, left first
	task automatic run(input int n);
		logic s;
		#7 slot(1'b1, 1'b0, s);
		slot(1'b0, 1'b0, s);
		for (int f = 0; f < n; f++) begin
			for (int j = 0; j < 32; j++) begin
				slot(j >= 15 && j < 31, txw[f][31 - j], s);
				rxw[f][31 - j] = s;
			end
		end
		// a released data line must not show a held bit
		#80 ws = 1'b1;
		sdi = ~sdi;
	endtask : run
endmodule : fmi2s_codec_model

/* File: dv/tb_top.sv */
// bench for the fm serial audio port: fill, slave drain, master frames.
// assumes the codec model on the pins and a 50 MHz mclk.
`timescale 1ns/1ps
module tb_top;
	localparam int DEPTH = 8;
	logic mclk, rst_n, masterMode, wideFrame, routeCtl, rxValid;
	logic [31:0] rxData;
	logic rxReady, txRight, txValid;
	logic [15:0] txData;
	logic vSckO, vSckE, vWsO, vWsE, vSdo, vSdoE;
	logic cSckO, cSckE, cWsO, cWsE, cSdo, cSdoE;
	logic mSck, mWs, mSdi;
	int errors = 0;
	int n_checks = 0;
	logic [31:0] sent [16];
	logic [16:0] capt [$];
	// pin levels from every party's enable
	wire vSck = vSckE ? vSckO : mSck;
	wire vWs = vWsE ? vWsO : mWs;
	wire cSck = cSckE ? cSckO : mSck;
	wire cWs = cWsE ? cWsO : mWs;
	wire pSck = routeCtl ? cSck : vSck;
	wire pWs = routeCtl ? cWs : vWs;
	// an undriven data line shows the inverse, so a lost enable is caught
	wire pSdo = routeCtl ? (cSdoE ? cSdo : ~cSdo) : (vSdoE ? vSdo : ~vSdo);
	////////////////////////////////////////////////////////////////////////
	fmi2s_port #(.DEPTH(DEPTH)) DUT (.mclk(mclk), .rst_n(rst_n),
		.clkEn(1'b1), .masterMode(masterMode), .wideFrame(wideFrame),
		.routeCtl(routeCtl), .rxData(rxData), .rxValid(rxValid),
		.rxReady(rxReady), .txData(txData), .txRight(txRight),
		.txValid(txValid), .voiceSckIn(vSck), .voiceSckOut(vSckO),
		.voiceSckOe(vSckE), .voiceWsIn(vWs), .voiceWsOut(vWsO),
		.voiceWsOe(vWsE), .voiceSdo(vSdo), .voiceSdoOe(vSdoE),
		.voiceSdi(mSdi), .ctlSckIn(cSck), .ctlSckOut(cSckO),
		.ctlSckOe(cSckE), .ctlWsIn(cWs), .ctlWsOut(cWsO), .ctlWsOe(cWsE),
		.ctlSdo(cSdo), .ctlSdoOe(cSdoE), .ctlSdi(mSdi));
	fmi2s_codec_model codec (.sck(mSck), .ws(mWs), .sdi(mSdi), .sdo(pSdo));
	////////////////////////////////////////////////////////////////////////
	// clock and captured transmit words
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	always @(negedge mclk) begin
		if (txValid === 1'b1)
			capt.push_back({txRight, txData});
	end
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic restart(input logic m, input logic w);
		@(negedge mclk);
		rst_n = 1'b0;
		masterMode = m;
		wideFrame = w;
		routeCtl = 1'b0;
		repeat (10) @(negedge mclk);
		rst_n = 1'b1;
		repeat (2) @(negedge mclk);
	endtask : restart
	// rise of sck, or fall of ws, seen at a falling mclk
	task automatic waitEdge(input logic useWs);
		logic s;
		s = useWs ? !pWs : pSck;
		for (int k = 0; k < 4000; k++) begin
			@(negedge mclk);
			if ((useWs ? !pWs : pSck) && !s)
				break;
			s = useWs ? !pWs : pSck;
		end
	endtask : waitEdge
	// push until refused; nothing drains with the codec idle
	task automatic t_fill;
		int cnt;
		cnt = 0;
		for (int k = 0; k < 16; k++) begin
			@(negedge mclk);
			rxValid = 1'b1;
			rxData = 32'hc0de8001 + 32'(k) * 32'h01030507;
			if (rxReady)
				sent[cnt++] = rxData;
		end
		@(negedge mclk);
		rxValid = 1'b0;
		check(64'(cnt), 64'(DEPTH + 1));
		$display("fill test done");
	endtask : t_fill
	// slave on control pins: drain nine words, then underrun zeros
	task automatic t_slave;
		for (int f = 0; f < 11; f++)
			codec.txw[f] = 32'h9a5c0f0f ^ (32'(f) * 32'h00a30111);
		capt.delete();
		codec.run(11);
		repeat (20) @(negedge mclk);
		check(64'(capt.size()), 64'd22);
		for (int f = 0; f < 11; f++) begin
			check(codec.rxw[f], f < 9 ? sent[f] : 32'h0);
			check(capt[2 * f], {1'b0, codec.txw[f][31:16]});
			check(capt[2 * f + 1], {1'b1, codec.txw[f][15:0]});
		end
		$display("slave test done");
	endtask : t_slave
	// master on voice pins: three words back to back, one empty frame
	task automatic t_master(input logic wide);
		int h;
		logic [63:0] gd, gw, ed, ew;
		logic [31:0] w;
		h = wide ? 25 : 16;
		restart(1'b1, wide);
		for (int k = 0; k < 3; k++) begin
			@(negedge mclk);
			rxValid = 1'b1;
			rxData = 32'h5a3c0f81 + 32'(k) * 32'h11f00e01;
			sent[k] = rxData;
		end
		@(negedge mclk);
		rxValid = 1'b0;
		// the first left start after the pushes pops the first word
		waitEdge(1'b1);
		waitEdge(1'b0);
		for (int f = 0; f < 4; f++) begin
			w = f < 3 ? sent[f] : 32'h0;
			gd = '0;
			gw = '0;
			ed = '0;
			ew = '0;
			for (int i = 0; i < 2 * h; i++) begin
				waitEdge(1'b0);
				gd[i] = pSdo;
				gw[i] = pWs;
				ew[i] = i >= h - 1 && i < 2 * h - 1;
				if (i < 16)
					ed[i] = w[31 - i];
				else if (i >= h && i < h + 16)
					ed[i] = w[15 - i + h];
			end
			check(gd, ed);
			check(gw, ew);
		end
		$display("master test done");
	endtask : t_master
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop
	////////////////////////////////////////////////////////////////////////
	// main sequence; slave first so the filled buffer drains there
	initial begin
		rst_n = 1'b0;
		masterMode = 1'b0;
		wideFrame = 1'b0;
		routeCtl = 1'b1;
		rxValid = 1'b0;
		rxData = '0;
		repeat (10) @(negedge mclk);
		rst_n = 1'b1;
		repeat (2) @(negedge mclk);
		t_fill();
		t_slave();
		t_master(1'b0);
		t_master(1'b1);
		report_and_stop();
	end
	// whole run needs about 0.3 ms; allow more than three times that
	initial begin
		#1ms;
		errors++;
		$display("watchdog expired");
		report_and_stop();
	end
endmodule : tb_top
